// ### verilog/mode_select_pkg.sv
// Purpose: Shared constants for the three-channel capture/compare mode select block
// Assumes: 32-bit APB data, 16-bit timer, one clock
// Notes: Offsets are byte addresses
package mode_select_pkg;
  localparam int CHANNELS = 3;
  localparam int MODE_W = 4;
  localparam int VALUE_W = 16;
  // Register byte offsets
  localparam logic [7:0] VALUE0_OFFSET = 8'h00;
  localparam logic [7:0] VALUE1_OFFSET = 8'h04;
  localparam logic [7:0] VALUE2_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0C;
  localparam logic [7:0] MODE_SEL_OFFSET = 8'h40;
  // Mode select field positions
  localparam int CHAN0_MODE_LSB = 0;
  localparam int CHAN1_MODE_LSB = 4;
  localparam int CHAN2_MODE_LSB = 8;
  localparam int MODE_SEL_W = 16;
  // Status field positions
  localparam int STAT_COMPARE_LSB = 0;
  localparam int STAT_CAPTURE_LSB = 3;
  localparam int STAT_HALL_BIT = 6;
  // Reset values
  localparam logic [15:0] MODE_SEL_RESET = 16'h0000;
  localparam logic [15:0] VALUE0_RESET = 16'h0000;
  localparam logic [15:0] VALUE1_RESET = 16'h0000;
  localparam logic [15:0] VALUE2_RESET = 16'h003C;
  // Mode codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_DIRECT = 4'h1;
  localparam logic [3:0] MODE_COMPL = 4'h2;
  localparam logic [3:0] MODE_BOTH = 4'h3;
  localparam logic [3:0] MODE_DBL_FIRST = 4'h4;
  localparam logic [3:0] MODE_DBL_RISE = 4'h4;
  localparam logic [3:0] MODE_DBL_FALL = 4'h5;
  localparam logic [3:0] MODE_DBL_ANY = 4'h6;
  localparam logic [3:0] MODE_DBL_LAST = 4'h7;
  localparam logic [3:0] MODE_HALL = 4'h8;
  localparam logic [3:0] MODE_HYST = 4'h9;
  localparam logic [3:0] MODE_MULTI_FIRST = 4'hA;

  // True for codes that capture the timer count
  function automatic logic is_capture(input logic [3:0] code);
    is_capture = (code >= MODE_DBL_FIRST && code <= MODE_DBL_LAST) || (code >= MODE_MULTI_FIRST);
  endfunction : is_capture

  // True for codes that compare the value against the timer
  function automatic logic is_compare(input logic [3:0] code);
    is_compare = (code >= MODE_DIRECT && code <= MODE_BOTH) || (code == MODE_HYST);
  endfunction : is_compare
endpackage : mode_select_pkg

// ### verilog/channel_slice.sv
// Purpose: One capture/compare channel steered by its 4-bit mode code
// Assumes: Capture input synchronous to pclk
// Notes: Pins and compare state are registered; capture hit is combinational
`timescale 1ns/10ps
module channel_slice (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [mode_select_pkg::MODE_W-1:0] mode,
  input wire logic [mode_select_pkg::VALUE_W-1:0] value,
  input wire logic [mode_select_pkg::VALUE_W-1:0] timer_count,
  input wire logic cap_in,
  output logic direct_out,
  output logic direct_oe_n,
  output logic compl_out,
  output logic compl_oe_n,
  output logic compare_state,
  output logic capture_hit
);
  import mode_select_pkg::*;

  logic cap_prev_reg, cap_prev_next;
  logic cmp_reg, cmp_next;
  logic dout_reg, dout_next, doe_n_reg, doe_n_next;
  logic cout_reg, cout_next, coe_n_reg, coe_n_next;
  logic rise, fall;

  assign rise = cap_in & ~cap_prev_reg;
  assign fall = ~cap_in & cap_prev_reg;

  // Edge choice per capture code; pairing detail is kept simple
  always_comb begin
    capture_hit = 1'b0;
    if (mode == MODE_DBL_RISE || mode == MODE_DBL_LAST) begin
      capture_hit = rise;
    end else if (mode == MODE_DBL_FALL) begin
      capture_hit = fall;
    end else if (mode == MODE_DBL_ANY) begin
      capture_hit = rise | fall;
    end else if (mode >= MODE_MULTI_FIRST) begin
      capture_hit = rise | fall;
    end
  end

  // Compare result and pin drive from the mode code
  always_comb begin
    cap_prev_next = cap_in;
    cmp_next = is_compare(mode) && (timer_count >= value);
    dout_next = 1'b0;
    doe_n_next = 1'b1; // Released for general I/O
    cout_next = 1'b0;
    coe_n_next = 1'b1;
    case (mode)
      MODE_DIRECT: begin
        dout_next = cmp_next;
        doe_n_next = 1'b0;
      end
      MODE_COMPL: begin
        cout_next = ~cmp_next;
        coe_n_next = 1'b0;
      end
      MODE_BOTH: begin
        dout_next = cmp_next;
        doe_n_next = 1'b0;
        cout_next = ~cmp_next;
        coe_n_next = 1'b0;
      end
      MODE_HYST: begin
        // Input high holds the output passive, giving the hysteresis-like band
        dout_next = cmp_next & ~cap_in;
        doe_n_next = 1'b0;
      end
      default: begin
        dout_next = 1'b0;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_prev_reg <= 1'b0;
      cmp_reg <= 1'b0;
      dout_reg <= 1'b0;
      doe_n_reg <= 1'b1;
      cout_reg <= 1'b0;
      coe_n_reg <= 1'b1;
    end else begin
      cap_prev_reg <= cap_prev_next;
      cmp_reg <= cmp_next;
      dout_reg <= dout_next;
      doe_n_reg <= doe_n_next;
      cout_reg <= cout_next;
      coe_n_reg <= coe_n_next;
    end
  end

  assign direct_out = dout_reg;
  assign direct_oe_n = doe_n_reg;
  assign compl_out = cout_reg;
  assign compl_oe_n = coe_n_reg;
  assign compare_state = cmp_reg;
endmodule : channel_slice

// ### verilog/timer_channel_mode_select.sv
// Purpose: APB-reached mode select and value registers for three capture/compare channels
// Assumes: Timer count and capture inputs synchronous to pclk
// Notes: Two-cycle APB access phase; all outputs registered
//   Map: 0x00, 0x04, 0x08 channel values, 0x0C status, 0x40 mode select
//   Status: 2:0 compare states, 5:3 capture flags (write one to clear), 6 Hall enable
//   Unmapped addresses answer with an error, read zero and drop writes
//   Hall edges are only flagged; no capture rides on them
//   Mode select bits 15:12 are plain storage with no effect
`timescale 1ns/10ps
module timer_channel_mode_select #(
  parameter int CHAN_COUNT = mode_select_pkg::CHANNELS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [mode_select_pkg::VALUE_W-1:0] main_channel_timer,
  input wire logic [mode_select_pkg::CHANNELS-1:0] capture_in,
  output logic [mode_select_pkg::CHANNELS-1:0] direct_compare_pin_out,
  output logic [mode_select_pkg::CHANNELS-1:0] direct_compare_pin_oe_n,
  output logic [mode_select_pkg::CHANNELS-1:0] complementary_compare_pin_out,
  output logic [mode_select_pkg::CHANNELS-1:0] complementary_compare_pin_oe_n,
  output logic hall_detect_enable,
  output logic hall_edge
);
  import mode_select_pkg::*;

  // Field layout is fixed at three channels; the register map has no room for more
  if (CHAN_COUNT != CHANNELS) begin : g_bad_count
    $error("CHAN_COUNT must be 3");
  end

  // Register state and its next values
  logic [MODE_SEL_W-1:0] mode_sel_reg, mode_sel_next;
  logic [VALUE_W-1:0] value_reg [CHANNELS], value_next [CHANNELS];
  logic [CHANNELS-1:0] cap_flag_reg, cap_flag_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic hall_en_reg, hall_en_next, hall_edge_reg, hall_edge_next;
  logic [CHANNELS-1:0] hall_prev_reg, hall_prev_next;
  // Field views, slice results and bus qualifiers
  logic [MODE_W-1:0] chan_mode [CHANNELS];
  logic [CHANNELS-1:0] cmp_state, cap_hit;
  logic wr_commit, rd_start, addr_ok;

  // Byte address of one channel's value register
  function automatic logic [7:0] value_addr(input int idx);
    case (idx)
      0: value_addr = VALUE0_OFFSET;
      1: value_addr = VALUE1_OFFSET;
      default: value_addr = VALUE2_OFFSET;
    endcase
  endfunction : value_addr

  // Any mapped register; everything else answers with an error
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == STATUS_OFFSET) || (a == MODE_SEL_OFFSET);
    for (int i = 0; i < CHANNELS; i++) begin
      addr_mapped = addr_mapped || (a == value_addr(i));
    end
  endfunction : addr_mapped

  // Mode fields of the select register
  assign chan_mode[0] = mode_sel_reg[CHAN0_MODE_LSB +: MODE_W]; // chan0_mode_field
  assign chan_mode[1] = mode_sel_reg[CHAN1_MODE_LSB +: MODE_W]; // chan1_mode_field
  assign chan_mode[2] = mode_sel_reg[CHAN2_MODE_LSB +: MODE_W]; // chan2_mode_field

  // Per-channel slices, each steered only by its own field
  generate
    for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
      channel_slice u_slice (
        .pclk(pclk),
        .presetn(presetn),
        .mode(chan_mode[i]),
        .value(value_reg[i]),
        .timer_count(main_channel_timer),
        .cap_in(capture_in[i]),
        .direct_out(direct_compare_pin_out[i]),
        .direct_oe_n(direct_compare_pin_oe_n[i]),
        .compl_out(complementary_compare_pin_out[i]),
        .compl_oe_n(complementary_compare_pin_oe_n[i]),
        .compare_state(cmp_state[i]),
        .capture_hit(cap_hit[i])
      );
    end
  endgenerate

  // APB phases: ready one cycle into access, write lands at the ready edge
  assign rd_start = psel & penable & ~pready_reg;
  assign wr_commit = psel & penable & pready_reg & pwrite;
  assign addr_ok = addr_mapped(paddr);

  // Bus answer; read data is taken one edge before ready, so a capture at the ready edge shows next read
  always_comb begin
    pready_next = rd_start;
    pslverr_next = rd_start & ~addr_ok;
    prdata_next = 32'h0000_0000;
    if (rd_start && !pwrite) begin
      // Value registers by channel
      for (int i = 0; i < CHANNELS; i++) begin
        if (paddr == value_addr(i)) begin
          prdata_next[VALUE_W-1:0] = value_reg[i];
        end
      end
      if (paddr == STATUS_OFFSET) begin
        prdata_next[STAT_COMPARE_LSB +: CHANNELS] = cmp_state;
        prdata_next[STAT_CAPTURE_LSB +: CHANNELS] = cap_flag_reg;
        prdata_next[STAT_HALL_BIT] = hall_en_reg;
      end
      if (paddr == MODE_SEL_OFFSET) begin
        prdata_next[MODE_SEL_W-1:0] = mode_sel_reg;
      end
    end
  end

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Mode select; written only at the ready edge of a mapped write
  always_comb begin
    mode_sel_next = mode_sel_reg;
    if (wr_commit && paddr == MODE_SEL_OFFSET) begin
      mode_sel_next = pwdata[MODE_SEL_W-1:0];
    end
  end

  // Mode select register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_sel_reg <= MODE_SEL_RESET;
    end else begin
      mode_sel_reg <= mode_sel_next;
    end
  end

  // Values and capture flags; a capture wins over a software write or clear in the same cycle
  always_comb begin
    cap_flag_next = cap_flag_reg;
    if (wr_commit && paddr == STATUS_OFFSET) begin
      cap_flag_next = cap_flag_reg & ~pwdata[STAT_CAPTURE_LSB +: CHANNELS];
    end
    for (int i = 0; i < CHANNELS; i++) begin
      value_next[i] = value_reg[i];
      // Software write first, so a capture below overrides it
      if (wr_commit && paddr == value_addr(i)) begin
        value_next[i] = pwdata[VALUE_W-1:0];
      end
      if (cap_hit[i] && is_capture(chan_mode[i])) begin
        value_next[i] = main_channel_timer;
        cap_flag_next[i] = 1'b1;
      end
    end
  end

  // Value and capture flag registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_reg[0] <= VALUE0_RESET;
      value_reg[1] <= VALUE1_RESET;
      value_reg[2] <= VALUE2_RESET;
      cap_flag_reg <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        value_reg[i] <= value_next[i];
      end
      cap_flag_reg <= cap_flag_next;
    end
  end

  // Hall detection; the previous pattern tracks even while off, so enabling raises no false edge
  always_comb begin
    hall_en_next = (chan_mode[0] == MODE_HALL) && (chan_mode[1] == MODE_HALL) &&
                   (chan_mode[2] == MODE_HALL);
    hall_prev_next = capture_in;
    hall_edge_next = hall_en_reg && (capture_in != hall_prev_reg);
  end

  // Hall registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hall_en_reg <= 1'b0;
      hall_edge_reg <= 1'b0;
      hall_prev_reg <= '0;
    end else begin
      hall_en_reg <= hall_en_next;
      hall_edge_reg <= hall_edge_next;
      hall_prev_reg <= hall_prev_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign hall_detect_enable = hall_en_reg;
  assign hall_edge = hall_edge_reg;
endmodule : timer_channel_mode_select

// ### bench/timer_channel_mode_select_monitor.sv
// Purpose: Port assertions for the mode select block
// Assumes: One clock domain
// Notes: Bound below the module
`timescale 1ns/10ps
module timer_channel_mode_select_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] capture_in,
  input wire logic [2:0] direct_compare_pin_out,
  input wire logic [2:0] direct_compare_pin_oe_n,
  input wire logic [2:0] complementary_compare_pin_out,
  input wire logic [2:0] complementary_compare_pin_oe_n,
  input wire logic hall_detect_enable,
  input wire logic hall_edge
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Short aliases for the pin vectors
  wire [2:0] doe = direct_compare_pin_oe_n;
  wire [2:0] dout = direct_compare_pin_out;
  wire [2:0] coe = complementary_compare_pin_oe_n;
  wire [2:0] cout = complementary_compare_pin_out;
  // Access phase is fixed, so the answer is a lone pulse
  sequence access_s; psel && penable && !pready; endsequence
  sequence pulse_s; pready ##1 !pready; endsequence
  sequence hall_move_s; hall_detect_enable && $changed(capture_in); endsequence
  answer_pulse_a: assert property (access_s |=> pulse_s) else $error("bad answer timing");
  error_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  idle_data_zero_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("stray read data");
  // Hall edges only while every field holds the Hall code
  hall_gate_a: assert property (hall_edge |-> $past(hall_detect_enable)) else $error("edge while disabled");
  hall_edge_cause_a: assert property (hall_move_s |=> hall_edge) else $error("hall edge missed");
  hall_pins_off_a: assert property (hall_detect_enable |-> &{doe, coe}) else $error("pin driven in hall");
  // A driven pair is always complementary; a released pin rests low
  pair_opposite_a: assert property ((~doe & ~coe & ~(dout ^ cout)) == 3'h0) else $error("pair equal");
  released_low_a: assert property (((doe & dout) | (coe & cout)) == 3'h0) else $error("released pin high");
endmodule : timer_channel_mode_select_monitor

bind timer_channel_mode_select timer_channel_mode_select_monitor monitor_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_in(capture_in),
  .direct_compare_pin_out(direct_compare_pin_out), .direct_compare_pin_oe_n(direct_compare_pin_oe_n),
  .complementary_compare_pin_out(complementary_compare_pin_out),
  .complementary_compare_pin_oe_n(complementary_compare_pin_oe_n), .hall_detect_enable(hall_detect_enable),
  .hall_edge(hall_edge));

// ### bench/pin_stage_model.sv
// Purpose: Timer count and capture pins facing the block
// Assumes: Bench picks the levels
// Notes: Levels move only just after an edge
`timescale 1ns/10ps
module pin_stage_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] timer_set,
  input wire logic [2:0] cap_set,
  output logic [15:0] main_channel_timer,
  output logic [2:0] capture_in
);
  // Registered so the block never sees a change at its sampling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_channel_timer <= 16'h0000;
      capture_in <= 3'h0;
    end else begin
      main_channel_timer <= timer_set;
      capture_in <= cap_set;
    end
  end
endmodule : pin_stage_model

// ### bench/tb_timer_channel_mode_select.sv
// Purpose: Self-checking bench for the mode select block
// Assumes: Fixed two-cycle APB answer
// Notes: Sweeps every mode code on all channels
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; $display("ERROR %0t mismatch", $time); end end
module tb_timer_channel_mode_select;
  import mode_select_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, hde, hedge, err, cmp;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, s = 32'h0000_005C;
  logic [15:0] timer_set = 16'h0000, t, v, m, timer;
  logic [2:0] cap_set = 3'h0, cap, doe, dout, coe, cout;
  int failures = 0, checks_done = 0;
  always #5 pclk = ~pclk;
  timer_channel_mode_select timer_channel_mode_select_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .main_channel_timer(timer), .capture_in(cap), .direct_compare_pin_out(dout),
    .direct_compare_pin_oe_n(doe), .complementary_compare_pin_out(cout), .complementary_compare_pin_oe_n(coe),
    .hall_detect_enable(hde), .hall_edge(hedge));
  pin_stage_model pin_stage_model_i (.pclk(pclk), .presetn(presetn), .timer_set(timer_set), .cap_set(cap_set),
    .main_channel_timer(timer), .capture_in(cap));
  // Xorshift source, fixed start for repeatable runs
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : rnd
  // Pins {direct oe_n, direct, compl oe_n, compl}; compl shows the inverse
  function automatic logic [3:0] pins(input logic [3:0] c, input logic q);
    case (c)
      4'h1, 4'h9: return {1'b0, q, 2'b10};
      4'h2: return {2'b10, 1'b0, ~q};
      4'h3: return {1'b0, q, 1'b0, ~q};
      default: return 4'b1010;
    endcase
  endfunction : pins
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) failures++;
  endtask : apb
  task automatic final_report();
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  // Cuts a hang short
  initial begin
    #100000;
    failures++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, MODE_SEL_OFFSET, '0);
    `CHK(rd[15:0], MODE_SEL_RESET)
    apb(1'b0, VALUE2_OFFSET, '0);
    `CHK(rd[15:0], VALUE2_RESET)
    apb(1'b0, 8'h20, '0);
    `CHK({err, rd}, 33'h1_0000_0000)
    // Every code on all channels; even codes hit the equal boundary
    for (int c = 0; c < 16; c++) begin
      t = rnd();
      v = (c == 9) ? 16'h0000 : (c[0] ? rnd() : t); // Code 9 starts with its compare true
      rd = rnd();
      m = {rd[15:12], c[3:0], c[3:0], c[3:0]};
      cmp = (c inside {1, 2, 3, 9}) && t >= v;
      timer_set <= t;
      for (int k = 0; k < 3; k++) apb(1'b1, 8'(4 * k), {16'h0000, v});
      apb(1'b1, MODE_SEL_OFFSET, {16'h0000, m});
      apb(1'b0, MODE_SEL_OFFSET, '0);
      `CHK(rd, {16'h0000, m})
      for (int k = 0; k < 3; k++) `CHK({doe[k], dout[k], coe[k], cout[k]}, pins(c[3:0], cmp))
      apb(1'b0, STATUS_OFFSET, '0);
      `CHK({hde, rd[6], rd[2:0]}, {c == 8, c == 8, {3{cmp}}})
      t = ~t; // New count, so a capture cannot pass by matching the written value
      timer_set <= t;
      cap_set <= 3'h7;
      repeat (3) @(posedge pclk);
      `CHK(hedge, c == 8)
      if (c == 9) `CHK(dout, 3'h0)
      apb(1'b0, VALUE0_OFFSET, '0);
      cmp = (c inside {4, 6, 7}) || c >= 10; // Rising edge; code 5 waits for a fall
      `CHK(rd[15:0], cmp ? t : v)
      apb(1'b0, STATUS_OFFSET, '0);
      `CHK(rd[5:3], {3{cmp}})
      v = cmp ? t : v;
      t = t + 16'h0101;
      timer_set <= t;
      cap_set <= 3'h0;
      repeat (3) @(posedge pclk);
      apb(1'b0, VALUE1_OFFSET, '0);
      `CHK(rd[15:0], ((c inside {5, 6}) || c >= 10) ? t : v)
      apb(1'b1, STATUS_OFFSET, 32'h0000_0038);
    end
    apb(1'b1, MODE_SEL_OFFSET, 32'h0000_0988);
    apb(1'b0, STATUS_OFFSET, '0);
    `CHK(rd[6], 1'b0)
    `CHK(hde, 1'b0)
    final_report();
  end
endmodule : tb_timer_channel_mode_select
